// file: sebl_pkg.sv
// sebl_pkg: constants, carriers and states of the serial eeprom boot loader.
// assumes one 100 MHz core clock and a synchronous active-high reset.
package sebl_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ       = 100_000_000;
    localparam int UART_BAUD    = 115200;
    localparam int UART_BIT_CYC = CLK_HZ / UART_BAUD;
    localparam int PB_HOLD_MS   = 5000;
    localparam int PB_HOLD_CYC  = PB_HOLD_MS * (CLK_HZ / 1000);
    localparam int SPI_HALF_CYC = 5;            // 10 MHz serial clock
    localparam int CS_GAP_NS    = 100;
    localparam int CS_GAP_CYC   = (CS_GAP_NS * (CLK_HZ / 1_000_000)
                                   + 999) / 1000;

    // ----------------------------------------------------------------
    // protocol values and byte positions
    // ----------------------------------------------------------------
    localparam logic [7:0]  SPI_READ_CMD = 8'h03;
    localparam logic [7:0]  EMU_BYTE     = 8'hef;
    localparam logic [7:0]  REC_START    = 8'h04;
    localparam logic [15:0] SIG_LAST     = 16'h0006;  // cmd, 2 addr, 4 sig
    localparam logic [15:0] CMD_LAST16   = 16'h0002;
    localparam logic [15:0] CMD_LAST24   = 16'h0003;
    localparam logic [15:0] HDR_TYPE     = 16'h0000;
    localparam logic [15:0] HDR_LEN_LO   = 16'h0001;
    localparam logic [15:0] HDR_LEN_HI   = 16'h0002;
    localparam logic [15:0] HDR_ADR_LO   = 16'h0003;
    localparam logic [15:0] HDR_ADR_HI   = 16'h0004;
    localparam logic [7:0]  TYPE_IMEM    = 8'h00;
    localparam logic [7:0]  TYPE_XMEM    = 8'h01;
    localparam logic [7:0]  TYPE_YMEM    = 8'h02;
    localparam logic [7:0]  TYPE_EXEC    = 8'h03;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
    } sebl_spi_t;

    typedef struct packed {
        logic        valid;
        logic [1:0]  space;     // 0 instr, 1 x, 2 y
        logic [15:0] addr;
        logic [7:0]  data;
    } sebl_mem_wr_t;

    typedef struct packed {
        logic por_ok;           // core supply good, low forces reset
        logic external_reset_n;
        logic watchdog;
        logic debugger;
        logic power_button;
    } sebl_rst_src_t;

    typedef struct packed {
        logic boot_strap_pin;
        logic eeprom_select_strap;
        logic parallel_flash_enable_strap;
    } sebl_straps_t;

    typedef enum logic [3:0] {
        ST_START = 4'b0000,
        ST_SIG   = 4'b0001,
        ST_GAP   = 4'b0011,
        ST_CMD   = 4'b0010,
        ST_HDR   = 4'b0110,
        ST_PAY   = 4'b0111,
        ST_EXEC  = 4'b0101,
        ST_FLASH = 4'b0100,
        ST_CARD  = 4'b1100,
        ST_ROM   = 4'b1101,
        ST_EMU   = 4'b1111
    } sebl_state_t;

endpackage

// file: sebl_spi_byte.sv
// sebl_spi_byte: one byte of mode 0 serial transfer, msb first.
// assumes miso is already synchronised; chip select is driven by the caller.
`timescale 1ns/10ps
module sebl_spi_byte #(
    parameter int HALF = sebl_pkg::SPI_HALF_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [7:0] tx_byte,
    input  wire logic       miso,
    output logic            rdy,
    output logic            done,
    output logic [7:0]      rx_byte,
    output logic            sclk,
    output logic            mosi
);
    import sebl_pkg::*;

    localparam int DW = $clog2(HALF + 1);

    logic          busy_r;
    logic [DW-1:0] div_r;
    logic [2:0]    bit_r;
    logic [7:0]    sh_r;
    logic          tick;

    if (HALF < 1) begin : g_bad_half
        $error("sebl_spi_byte: HALF must be at least 1");
    end

    assign rdy  = ~busy_r;
    assign tick = busy_r && (div_r == DW'(HALF - 1));

    // ------------------------------------------------------------
    // half-period divider, runs only while a byte is moving
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst || !busy_r || tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + DW'(1);
        end
    end

    // shift engine: data set up before rise, sampled on rise
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busy_r  <= 1'b0;
            bit_r   <= 3'd0;
            sh_r    <= 8'h00;
            sclk    <= 1'b0;
            mosi    <= 1'b0;
            done    <= 1'b0;
            rx_byte <= 8'h00;
        end else begin
            done <= 1'b0;
            if (start && !busy_r) begin
                busy_r <= 1'b1;
                bit_r  <= 3'd0;
                sh_r   <= tx_byte;
                mosi   <= tx_byte[7];
            end else if (tick && !sclk) begin
                sclk    <= 1'b1;
                rx_byte <= {rx_byte[6:0], miso};
            end else if (tick) begin
                sclk <= 1'b0;
                if (bit_r == 3'd7) begin
                    busy_r <= 1'b0;
                    done   <= 1'b1;
                end else begin
                    bit_r <= bit_r + 3'd1;
                    sh_r  <= {sh_r[6:0], 1'b0};
                    mosi  <= sh_r[6];   // next bit, low clock phase
                end
            end
        end
    end

endmodule // sebl_spi_byte

// file: sebl_loader.sv
// sebl_loader: boot sequencer with serial eeprom record loader.
// assumes pins arrive asynchronously; watchdog and debugger resets
// come from logic on clk_sys.
`timescale 1ns/10ps

module sebl_loader #(
    parameter int          UART_BIT   = sebl_pkg::UART_BIT_CYC,
    parameter int          PB_HOLD    = sebl_pkg::PB_HOLD_CYC,
    parameter int          SPI_HALF   = sebl_pkg::SPI_HALF_CYC,
    parameter logic [31:0] SIG_PROT   = 32'h5a4b_3c01, // arbitrary value
    parameter logic [31:0] SIG_OPEN   = 32'h694b_3c01, // arbitrary value
    parameter logic [23:0] SIG_PREFIX = 24'h5a_4b3c    // arbitrary value
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire sebl_pkg::sebl_rst_src_t rst_src,
    input  wire sebl_pkg::sebl_straps_t straps,
    input  wire logic                   uart_rx,
    input  wire logic                   spi_miso,
    output sebl_pkg::sebl_spi_t         spi,
    output sebl_pkg::sebl_mem_wr_t      mem_wr,
    output logic                        exec_valid,
    output logic [15:0]                 exec_addr,
    output logic                        flash_probe_req,
    input  wire logic                   flash_probe_done,
    output logic                        card_boot_req,
    input  wire logic                   card_boot_done,
    output logic                        rom_handoff,
    output logic                        emu_mode,
    output logic                        sys_reset
);
    import sebl_pkg::*;

    localparam int PBW = $clog2(PB_HOLD + 1);
    localparam int UBW = $clog2(UART_BIT + 1);

    if (UART_BIT < 4 || PB_HOLD < 2) begin : g_bad_param
        $error("sebl_loader: UART_BIT or PB_HOLD too small");
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [7:0] pin_a;
    logic [7:0] pin_m_r;        // first stage, read only by pin_s_r
    logic [7:0] pin_s_r;

    assign pin_a = {rst_src.por_ok, rst_src.external_reset_n,
                    rst_src.power_button, straps.boot_strap_pin,
                    straps.eeprom_select_strap,
                    straps.parallel_flash_enable_strap,
                    uart_rx, spi_miso};

    // no reset here: the chain fills while rst is held
    always_ff @(posedge clk_sys) begin
        pin_m_r <= pin_a;
        pin_s_r <= pin_m_r;
    end

    logic por_ok_s;
    logic ext_n_s;
    logic btn_s;
    logic boot_s;
    logic eep_s;
    logic flash_s;
    logic rx_s;
    logic miso_s;

    assign {por_ok_s, ext_n_s, btn_s, boot_s, eep_s, flash_s,
            rx_s, miso_s} = pin_s_r;

    // ----------------------------------------------------------------
    // reset combiner
    // ----------------------------------------------------------------
    logic           int_rst_r;
    logic [PBW-1:0] pb_cnt_r;
    logic           pb_long_r;
    logic           rst_any;

    // button hold timer; the outer reset and a released button clear it, the
    // internal reset does not, otherwise the reset it causes would cancel itself
    always_ff @(posedge clk_sys) begin
        if (rst || !btn_s) begin
            pb_cnt_r  <= '0;
            pb_long_r <= 1'b0;
        end else if (pb_cnt_r == PBW'(PB_HOLD - 1)) begin
            pb_long_r <= 1'b1;
        end else begin
            pb_cnt_r <= pb_cnt_r + PBW'(1);
        end
    end

    // any source holds the internal reset, which restarts the sequence
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            int_rst_r <= 1'b1;
        end else begin
            int_rst_r <= !por_ok_s || !ext_n_s
                         || rst_src.watchdog || rst_src.debugger
                         || pb_long_r;
        end
    end

    assign rst_any   = rst || int_rst_r;
    assign sys_reset = int_rst_r;

    // ----------------------------------------------------------------
    // serial receiver watching for the emulator byte
    // ----------------------------------------------------------------
    logic           u_busy_r;
    logic [UBW-1:0] u_cnt_r;
    logic [3:0]     u_bit_r;
    logic [7:0]     u_sh_r;
    logic           emu_hit_r;

    // sample mid-bit, lsb first; a false start bit is dropped
    always_ff @(posedge clk_sys) begin
        if (rst_any) begin
            u_busy_r  <= 1'b0;
            u_cnt_r   <= '0;
            u_bit_r   <= 4'd0;
            u_sh_r    <= 8'h00;
            emu_hit_r <= 1'b0;
        end else begin
            emu_hit_r <= 1'b0;
            if (!u_busy_r) begin
                if (!rx_s) begin
                    u_busy_r <= 1'b1;
                    u_bit_r  <= 4'd0;
                    u_cnt_r  <= UBW'(UART_BIT / 2);
                end
            end else if (u_cnt_r != '0) begin
                u_cnt_r <= u_cnt_r - UBW'(1);
            end else begin
                u_cnt_r <= UBW'(UART_BIT - 1);
                u_bit_r <= u_bit_r + 4'd1;
                if (u_bit_r == 4'd0 && rx_s) begin
                    u_busy_r <= 1'b0;
                end else if (u_bit_r == 4'd9) begin
                    u_busy_r  <= 1'b0;
                    emu_hit_r <= rx_s && (u_sh_r == EMU_BYTE);
                end else if (u_bit_r != 4'd0) begin
                    u_sh_r <= {rx_s, u_sh_r[7:1]};
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // serial eeprom engine
    // ----------------------------------------------------------------
    sebl_state_t st_r;
    logic [15:0] cnt_r;
    logic        cs_n_r;
    logic        mode24_r;
    logic [7:0]  type_r;
    logic [15:0] len_r;
    logic [15:0] adr_r;
    logic [31:0] sig_r;
    logic [31:0] sig_now;
    logic [15:0] cmd_last;
    logic        spi_active;
    logic        spi_start;
    logic        spi_rdy;
    logic        spi_done;
    logic [7:0]  spi_rx;
    logic [7:0]  spi_tx;
    logic        spi_sclk;
    logic        spi_mosi;

    sebl_spi_byte #(
        .HALF    (SPI_HALF)
    ) u_spi (
        .clk_sys (clk_sys),
        .rst     (rst_any),
        .start   (spi_start),
        .tx_byte (spi_tx),
        .miso    (miso_s),
        .rdy     (spi_rdy),
        .done    (spi_done),
        .rx_byte (spi_rx),
        .sclk    (spi_sclk),
        .mosi    (spi_mosi)
    );

    assign spi = '{cs_n: cs_n_r, sclk: spi_sclk, mosi: spi_mosi};

    assign sig_now  = {sig_r[23:0], spi_rx};
    assign cmd_last = mode24_r ? CMD_LAST24 : CMD_LAST16;
    assign spi_active = (st_r == ST_SIG) || (st_r == ST_CMD)
                        || (st_r == ST_HDR) || (st_r == ST_PAY);
    // one idle cycle after each byte keeps start and done apart
    assign spi_start = spi_active && spi_rdy && !spi_done;

    // outgoing byte: read command, then address msb first
    always_comb begin
        spi_tx = 8'h00;
        if (cnt_r == 16'h0000 && (st_r == ST_SIG || st_r == ST_CMD)) begin
            spi_tx = SPI_READ_CMD;
        end else if (st_r == ST_CMD && cnt_r == cmd_last) begin
            spi_tx = REC_START;
        end
    end

    // signature shift register, first byte ends up on top
    always_ff @(posedge clk_sys) begin
        if (rst_any) begin
            sig_r <= 32'h0000_0000;
        end else if (st_r == ST_SIG && spi_done) begin
            sig_r <= sig_now;
        end
    end

    // record header capture
    always_ff @(posedge clk_sys) begin
        if (rst_any) begin
            type_r <= 8'h00;
            len_r  <= 16'h0000;
            adr_r  <= 16'h0000;
        end else if (st_r == ST_HDR && spi_done) begin
            unique case (cnt_r)
                HDR_TYPE:   type_r       <= spi_rx;
                HDR_LEN_LO: len_r[7:0]   <= spi_rx;
                HDR_LEN_HI: len_r[15:8]  <= spi_rx;
                HDR_ADR_LO: adr_r[7:0]   <= spi_rx;
                HDR_ADR_HI: adr_r[15:8]  <= spi_rx;
                default:    type_r       <= type_r;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // boot sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst_any) begin
            st_r     <= ST_START;
            cnt_r    <= 16'h0000;
            cs_n_r   <= 1'b1;
            mode24_r <= 1'b0;
        end else if (emu_hit_r && st_r != ST_EMU) begin
            st_r   <= ST_EMU;
            cs_n_r <= 1'b1;
        end else begin
            unique case (st_r)
                ST_START: begin
                    cnt_r <= 16'h0000;
                    if (boot_s && eep_s) begin
                        st_r   <= ST_SIG;
                        cs_n_r <= 1'b0;
                    end else begin
                        st_r <= ST_FLASH;
                    end
                end
                ST_SIG: begin
                    if (spi_done && cnt_r == SIG_LAST) begin
                        cs_n_r <= 1'b1;
                        cnt_r  <= 16'h0000;
                        if (sig_now == SIG_PROT
                            || sig_now == SIG_OPEN) begin
                            mode24_r <= 1'b0;
                            st_r     <= ST_GAP;
                        end else if (sig_now[23:0] == SIG_PREFIX) begin
                            mode24_r <= 1'b1;
                            st_r     <= ST_GAP;
                        end else begin
                            st_r <= ST_FLASH;
                        end
                    end else if (spi_done) begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                ST_GAP: begin
                    if (cnt_r == 16'(CS_GAP_CYC - 1)) begin
                        st_r   <= ST_CMD;
                        cs_n_r <= 1'b0;
                        cnt_r  <= 16'h0000;
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                ST_CMD: begin
                    if (spi_done && cnt_r == cmd_last) begin
                        st_r  <= ST_HDR;
                        cnt_r <= 16'h0000;
                    end else if (spi_done) begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                ST_HDR: begin
                    if (spi_done && cnt_r == HDR_ADR_HI) begin
                        cnt_r <= 16'h0000;
                        if (type_r == TYPE_EXEC) begin
                            st_r   <= ST_EXEC;
                            cs_n_r <= 1'b1;
                        end else if (len_r != 16'h0000) begin
                            st_r <= ST_PAY;
                        end
                    end else if (spi_done) begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                ST_PAY: begin
                    if (spi_done && cnt_r == len_r - 16'h0001) begin
                        st_r  <= ST_HDR;
                        cnt_r <= 16'h0000;
                    end else if (spi_done) begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                ST_FLASH: begin
                    if (!flash_s || flash_probe_done) begin
                        st_r <= ST_CARD;
                    end
                end
                ST_CARD: begin
                    if (card_boot_done) begin
                        st_r <= ST_ROM;
                    end
                end
                ST_EXEC, ST_ROM, ST_EMU: begin
                    st_r <= st_r;
                end
                default: begin
                    st_r   <= ST_START;
                    cs_n_r <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // memory write port; byte address is record address plus offset
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst_any) begin
            mem_wr <= '0;
        end else begin
            mem_wr.valid <= 1'b0;
            if (st_r == ST_PAY && spi_done && type_r < TYPE_EXEC) begin
                mem_wr.valid <= 1'b1;
                mem_wr.space <= type_r[1:0];
                mem_wr.addr  <= adr_r + cnt_r;
                mem_wr.data  <= spi_rx;
            end
        end
    end

    // ----------------------------------------------------------------
    // stage outputs, decoded from the state register, flash request also gated by the flash strap; exec_addr is the record address
    // ----------------------------------------------------------------
    assign exec_valid      = (st_r == ST_EXEC);
    assign exec_addr       = adr_r;
    assign flash_probe_req = (st_r == ST_FLASH) && flash_s;
    assign card_boot_req   = (st_r == ST_CARD);
    assign rom_handoff     = (st_r == ST_ROM);
    assign emu_mode        = (st_r == ST_EMU);

endmodule // sebl_loader

// file: sebl_eeprom_model.sv
// sebl_eeprom_model: behavioural serial eeprom that answers read commands.
// assumes mode 0 from the loader; the bench fills mem and sets wide.
`timescale 1ns/10ps
module sebl_eeprom_model (
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic mosi,
    input  wire logic wide,
    output logic      miso
);
    // ----------------------------------------------------------------
    // serial read engine
    // ----------------------------------------------------------------
    logic [7:0] mem [0:255];
    logic [7:0] sh, a, d;
    int         n, h;
    logic       ok;
    initial begin
        miso = 1'b0;
        ok = 1'b0;
        n = 0;
        h = 99;
    end
    // shift in on the rise, msb first; a wrong command gets no data
    always @(posedge sclk or negedge cs_n) begin
        if (!sclk) n = 0;
        else begin
            sh = {sh[6:0], mosi};
            n = n + 1;
            h = wide ? 32 : 24;
            if (n == 8) ok = (sh == 8'h03);
            if (n == h) a = sh;
        end
    end
    // drive on the fall; no pull, so a released line shows its inverse
    always @(negedge sclk or posedge cs_n) begin
        d = 8'((n - h) / 8);
        if (cs_n || !ok || n < h) miso = ~miso;
        else miso = mem[a + d][3'(7 - (n - h) % 8)];
    end
endmodule // sebl_eeprom_model

// file: sebl_loader_assertions.sv
// sebl_loader_assertions: port checks of the boot loader.
// assumes only the loader's ports; bound into it below.
`timescale 1ns/10ps
module sebl_loader_assertions (
    input wire logic                    clk_sys,
    input wire logic                    rst,
    input wire sebl_pkg::sebl_rst_src_t rst_src,
    input wire sebl_pkg::sebl_spi_t     spi,
    input wire sebl_pkg::sebl_mem_wr_t  mem_wr,
    input wire logic                    exec_valid,
    input wire logic                    flash_probe_req,
    input wire logic                    flash_probe_done,
    input wire logic                    card_boot_req,
    input wire logic                    rom_handoff,
    input wire logic                    emu_mode,
    input wire logic                    sys_reset
);
    import sebl_pkg::*;
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sclk_idle_a: assert property (spi.cs_n |-> !spi.sclk)
        else $error("sclk high while deselected");
    mosi_hold_a: assert property (spi.sclk && $past(spi.sclk) |->
        $stable(spi.mosi)) else $error("mosi moved while sclk high");
    wr_pulse_a: assert property (mem_wr.valid |=> !mem_wr.valid)
        else $error("write strobe longer than one cycle");
    wr_space_a: assert property (mem_wr.valid |-> mem_wr.space != 2'h3
        && !spi.cs_n) else $error("write outside a load record");
    stage_one_a: assert property ($onehot0({exec_valid, flash_probe_req,
        card_boot_req, rom_handoff, emu_mode})) else $error("two stages");
    flash_next_a: assert property (flash_probe_req && flash_probe_done
        |=> card_boot_req) else $error("card stage late");
    cs_gap_a: assert property ($rose(spi.cs_n) |=> spi.cs_n [*8])
        else $error("chip select gap short");
    pin_reset_a: assert property (!rst_src.external_reset_n |->
        ##[1:5] sys_reset) else $error("pin reset lost");
endmodule // sebl_loader_assertions
bind sebl_loader sebl_loader_assertions u_chk (.*);

// file: tb_serial_eeprom_boot_loader.sv
// tb_serial_eeprom_boot_loader: random boot images and stage walks.
// assumes the loader reads the eeprom model; stage inputs come from here.
`timescale 1ns/10ps
module tb_serial_eeprom_boot_loader;
    import sebl_pkg::*;
    // ----------------------------------------------------------------
    // harness
    // ----------------------------------------------------------------
    localparam int UB = 16;                 // short bit time keeps runs brief
    localparam int PB = 20;
    localparam logic [31:0] SP = 32'h5a4b_3c01; // arbitrary value
    localparam logic [31:0] SO = 32'h694b_3c01; // arbitrary value
    localparam logic [23:0] SX = 24'h5a_4b3c;   // arbitrary value
    logic clk_sys, rst, uart_rx, spi_miso, fdone, cdone, wide;
    sebl_rst_src_t rsrc;
    sebl_straps_t  straps;
    sebl_spi_t     spi;
    sebl_mem_wr_t  mem_wr;
    wire [4:0]     st;
    wire           sr;
    logic [15:0]   exec_addr, ea;
    logic [31:0]   lf;
    logic [25:0]   q[$];
    int            err_count, tests_run, c0;
    int            cs_cyc = 0;      // cycles seen with chip select low
    sebl_loader #(.UART_BIT(UB), .PB_HOLD(PB), .SIG_PROT(SP), .SIG_OPEN(SO),
        .SIG_PREFIX(SX)) u_dut (.clk_sys(clk_sys), .rst(rst), .rst_src(rsrc),
        .straps(straps), .uart_rx(uart_rx), .spi_miso(spi_miso), .spi(spi),
        .mem_wr(mem_wr), .exec_valid(st[0]), .exec_addr(exec_addr),
        .flash_probe_req(st[1]), .flash_probe_done(fdone),
        .card_boot_req(st[2]), .card_boot_done(cdone), .rom_handoff(st[3]),
        .emu_mode(st[4]), .sys_reset(sr));
    sebl_eeprom_model u_mem (.cs_n(spi.cs_n), .sclk(spi.sclk),
        .mosi(spi.mosi), .wide(wide), .miso(spi_miso));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    function automatic logic [7:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf[7:0];
    endfunction
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task print_verdict();
        if (err_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // writes are checked as they land, against the queue built per image
    always @(posedge clk_sys) begin
        if (spi.cs_n === 1'b0) cs_cyc <= cs_cyc + 1;
        if (mem_wr.valid === 1'b1)
            chk(mem_wr[25:0], q.size() ? q.pop_front() : '1);
    end
    task step(input int c);
        repeat (c) @(negedge clk_sys);
    endtask
    task wt();
        for (int i = 0; i < 8000 && st === 5'h00; i++) step(1);
    endtask
    task uart(input logic [7:0] d);
        for (int i = 0; i < 10; i++) begin
            uart_rx = i == 0 ? 1'b0 : i == 9 ? 1'b1 : d[i - 1];
            step(UB);
        end
        step(8);
    endtask
    // ----------------------------------------------------------------
    // one boot per kind: 0..2 good images, 3..5 stage walks
    // ----------------------------------------------------------------
    task boot(input int k);
        int p, t, n;
        logic [15:0] a;
        logic [7:0]  b;
        straps = {k != 4, 1'b1, k != 5};
        wide = (k == 2);
        for (p = 0; p < 256; p++) u_mem.mem[p] = 8'h00;
        {u_mem.mem[0], u_mem.mem[1], u_mem.mem[2], u_mem.mem[3]} = k == 0 ?
            SP : k == 1 ? SO : k == 2 ? {SX, 8'h35} : 32'h0;
        p = 4;
        for (int r = 0; r < 4 && k < 3; r++) begin
            t = r == 3 ? 3 : r == 1 ? 4 + rnd() % 252 : (k + r / 2) % 3;
            n = r == 3 ? 0 : rnd() % 4;
            a = {rnd(), rnd()};
            ea = a;
            {u_mem.mem[p + 4], u_mem.mem[p + 3], u_mem.mem[p + 2],
                u_mem.mem[p + 1], u_mem.mem[p]} = {a, 8'h00, 8'(n), 8'(t)};
            p = p + 5;
            for (int i = 0; i < n; i++) begin
                b = rnd();
                u_mem.mem[p++] = b;
                if (t < 3) q.push_back({2'(t), a + 16'(i), b});
            end
        end
        rst = 1'b1;
        step(5);
        rst = 1'b0;
        c0 = cs_cyc;
        wt();
        chk(cs_cyc != c0, k != 4);
        if (k < 3) begin
            chk(st, 5'h01);
            chk(exec_addr, ea);
            chk(q.size(), 0);
            return;
        end
        chk(st, k == 5 ? 5'h04 : 5'h02);
        if (k == 5) begin
            uart(8'hef);
            chk(st, 5'h10);
            rsrc.power_button = 1'b1;
            step(PB + 6);
            chk(sr, 1'b1);
            rsrc = 5'b11000;
            step(5);
            chk(sr, 1'b0);
            rsrc = 5'b10000;
            step(4);
            chk(sr, 1'b1);
            rsrc = 5'b01000;
            step(4);
            chk(sr, 1'b1);
            rsrc = 5'b11000;
            return;
        end
        fdone = 1'b1;
        step(1);
        fdone = 1'b0;
        chk(st, 5'h04);
        cdone = 1'b1;
        step(1);
        cdone = 1'b0;
        chk(st, 5'h08);
        // k 3 pulses the debugger, k 4 the watchdog; k 3 also drops select
        rsrc = {2'b11, k == 4, k == 3, 1'b0};
        straps.eeprom_select_strap = k != 3;
        c0 = cs_cyc;
        step(1);
        rsrc = 5'b11000;
        step(4);
        wt();
        chk(st, 5'h02);
        chk(cs_cyc, c0);
    endtask
    initial begin
        {rst, uart_rx, fdone, cdone, wide} = 5'b11000;
        rsrc = 5'b11000;
        straps = '1;
        lf = 84188;
        err_count = 0;
        tests_run = 0;
        for (int k = 0; k < 6; k++) boot(k);
        print_verdict();
    end
    initial begin
        #600000;
        err_count++;
        print_verdict();
    end
endmodule // tb_serial_eeprom_boot_loader
